// ---- src/omt_tuning_seq.sv ----
`include "omt_consts.svh"

// Behaviour
// - selection 21 measures motor constants with no rotation command
// - start by run key in panel mode or start input in external mode
// - shutoff, fault clear, stop key or start release (external mode only) end tuning in error
// - while tuning only listed inputs act; other outputs held low
// - speed or frequency monitor shows progress in eight steps
// - motion-active output rises as tuning starts
// - status reads 21 set, 22 running, 23 normal end
// - tuning lasts about nine seconds, a parameter
// - after normal end, stop key or start release clears; refuse until then
// - changing selection after completion invalidates stored data
// - error end reports code 8, 9, 91, 92 or 93
// - error end leaves constants unset; inverter reset needed
// - measured constants stored and held until next good run
// - power loss gives error; on return normal run follows start
// - alarms during tuning handled as in ordinary operation
// - set frequency monitor reads zero while tuning
module omt_tuning_seq #(
  parameter int unsigned TUNE_CYCLES =
    `OMT_TUNE_TIME_MS * `OMT_CLK_KHZ
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  output logic irq_o,
  input wire logic run_key_i,
  input wire logic stop_key_i,
  input wire logic forward_start_input_i,
  input wire logic reverse_start_input_i,
  input wire logic output_shutoff_input_i,
  input wire logic fault_clear_input_i,
  input wire logic main_power_ok_i,
  input wire logic protective_trip_i,
  input wire logic current_limit_i,
  input wire logic dc_bus_high_i,
  input wire logic calc_error_i,
  input wire logic [15:0] meas_r1_i,
  input wire logic [7:0] monitor_i,
  input wire logic [7:0] set_freq_i,
  input wire logic [3:0] aux_out_i,
  output logic run_cmd_o,
  output logic motion_active_o,
  output logic [7:0] analog_monitor_output_o,
  output logic fault_relay_o,
  output logic [7:0] set_freq_mon_o,
  output logic [3:0] aux_out_o
);

  localparam int NPIN = 11;
  localparam int P_RUN = 0;
  localparam int P_STOP = 1;
  localparam int P_FWD = 2;
  localparam int P_REV = 3;
  localparam int P_MRS = 4;
  localparam int P_FCLR = 5;
  localparam int P_PWR = 6;
  localparam int P_TRIP = 7;
  localparam int P_ILIM = 8;
  localparam int P_DCV = 9;
  localparam int P_CALC = 10;
  localparam logic [31:0] STEP_CYCLES =
    32'(TUNE_CYCLES / `OMT_STEPS);

  omt_pkg::omt_state_t state_reg;
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] sync1_reg;
  logic [NPIN-1:0] sync2_reg;
  logic [NPIN-1:0] prev_reg;
  logic [3:0] ctrl_reg;
  logic [7:0] sel_reg;
  logic [7:0] err_code_reg;
  logic [15:0] r1_reg;
  logic r1_valid_reg;
  logic [2:0] irq_st_reg;
  logic [2:0] irq_st_next;
  logic [2:0] mask_reg;
  logic [31:0] sub_cnt_reg;
  logic [2:0] step_reg;
  logic [31:0] rdata_reg;
  logic irq_reg;
  logic run_cmd_reg;
  logic motion_reg;
  logic [7:0] analog_reg;
  logic fault_relay_reg;
  logic [7:0] set_freq_reg;
  logic [3:0] aux_out_reg;

  logic pu_mode;
  logic stall_off;
  logic start_lvl;
  logic pwr_ok;
  logic run_rise;
  logic stop_rise;
  logic fclr_rise;
  logic pwr_rise;
  logic start_req;
  logic forced_end;
  logic err_hit;
  logic [7:0] err_code;
  logic tune_done;
  logic tuning;
  logic run_now;
  logic ack;
  logic tsel_wr;
  logic [7:0] tsel_rd;

  assign pin_raw = {calc_error_i, dc_bus_high_i, current_limit_i,
                    protective_trip_i, main_power_ok_i,
                    fault_clear_input_i, output_shutoff_input_i,
                    reverse_start_input_i, forward_start_input_i,
                    stop_key_i, run_key_i};

  // two-stage pin synchronisers
  for (genvar g = 0; g < NPIN; g++) begin : g_sync
    always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
        sync1_reg[g] <= 1'b0;
        sync2_reg[g] <= 1'b0;
        prev_reg[g] <= 1'b0;
      end else begin
        sync1_reg[g] <= pin_raw[g];
        sync2_reg[g] <= sync1_reg[g];
        prev_reg[g] <= sync2_reg[g];
      end
    end
  end

  assign pu_mode = ctrl_reg[`OMT_CTRL_PU];
  assign stall_off = ctrl_reg[`OMT_CTRL_STALL_OFF];
  assign start_lvl = sync2_reg[P_FWD] | sync2_reg[P_REV];
  assign pwr_ok = sync2_reg[P_PWR];
  assign run_rise = sync2_reg[P_RUN] & ~prev_reg[P_RUN];
  assign stop_rise = sync2_reg[P_STOP] & ~prev_reg[P_STOP];
  assign fclr_rise = sync2_reg[P_FCLR] & ~prev_reg[P_FCLR];
  assign pwr_rise = sync2_reg[P_PWR] & ~prev_reg[P_PWR];
  assign tsel_wr = wr_i && (addr_i == `OMT_ADDR_TSEL);
  assign tuning = (state_reg == omt_pkg::OMT_RUNNING);

  // start needs main power and an arming selection
  assign start_req = pwr_ok &
    (pu_mode ? run_rise : start_lvl);

  // shutoff, fault clear, stop key and start release in external mode force the end
  assign forced_end = sync2_reg[P_MRS] | sync2_reg[P_FCLR] |
    sync2_reg[P_STOP] | (~pu_mode & ~start_lvl);

  always_comb begin
    err_code = `OMT_ERR_NONE;
    if (!pwr_ok || sync2_reg[P_TRIP]) begin
      err_code = `OMT_ERR_TRIP;
    end else if (forced_end) begin
      err_code = `OMT_ERR_FORCED;
    end else if (sync2_reg[P_ILIM] && !stall_off) begin
      err_code = `OMT_ERR_ILIM;
    end else if (sync2_reg[P_DCV]) begin
      err_code = `OMT_ERR_DCV;
    end else if (sync2_reg[P_CALC]) begin
      err_code = `OMT_ERR_CALC;
    end
  end

  assign err_hit = (err_code != `OMT_ERR_NONE);
  assign tune_done = (step_reg == 3'(`OMT_STEPS - 1)) &&
    (sub_cnt_reg == STEP_CYCLES - 32'h1);
  assign run_now = (state_reg == omt_pkg::OMT_ARMED && start_req) ||
    (tuning && !err_hit && !tune_done);
  assign ack = pu_mode ? stop_rise : ~start_lvl;

  // tuning sequencer
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_reg <= omt_pkg::OMT_IDLE;
    end else begin
      unique case (state_reg)
        omt_pkg::OMT_IDLE: begin
          if (tsel_wr && wdata_i[7:0] == `OMT_SEL_TUNE) begin
            state_reg <= omt_pkg::OMT_ARMED;
          end
        end
        omt_pkg::OMT_ARMED: begin
          if (tsel_wr && wdata_i[7:0] != `OMT_SEL_TUNE) begin
            state_reg <= omt_pkg::OMT_IDLE;
          end else if (start_req) begin
            state_reg <= omt_pkg::OMT_RUNNING;
          end
        end
        omt_pkg::OMT_RUNNING: begin
          if (err_hit) begin
            state_reg <= omt_pkg::OMT_DONE_ERR;
          end else if (tune_done) begin
            state_reg <= omt_pkg::OMT_DONE_OK;
          end
        end
        omt_pkg::OMT_DONE_OK: begin
          if (ack) begin
            state_reg <= omt_pkg::OMT_IDLE;
          end
        end
        omt_pkg::OMT_DONE_ERR: begin
          // inverter reset or power return
          if (fclr_rise || pwr_rise) begin
            state_reg <= omt_pkg::OMT_IDLE;
          end
        end
        default: state_reg <= omt_pkg::OMT_IDLE;
      endcase
    end
  end

  // progress timer in eight steps
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sub_cnt_reg <= 32'h0;
      step_reg <= 3'h0;
    end else if (!tuning) begin
      sub_cnt_reg <= 32'h0;
      step_reg <= 3'h0;
    end else if (sub_cnt_reg == STEP_CYCLES - 32'h1) begin
      sub_cnt_reg <= 32'h0;
      step_reg <= step_reg + 3'h1;
    end else begin
      sub_cnt_reg <= sub_cnt_reg + 32'h1;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      err_code_reg <= `OMT_ERR_NONE;
    end else if (tuning && err_hit) begin
      err_code_reg <= err_code;
    end else if (state_reg == omt_pkg::OMT_ARMED) begin
      err_code_reg <= `OMT_ERR_NONE;
    end
  end

  // measured constants and their validity
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      r1_reg <= 16'h0;
      r1_valid_reg <= 1'b0;
    end else if (tuning && !err_hit && tune_done) begin
      r1_reg <= meas_r1_i;
      r1_valid_reg <= 1'b1;
    end else if (tsel_wr && r1_valid_reg &&
                 wdata_i[7:0] != sel_reg) begin
      r1_valid_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctrl_reg <= `OMT_CTRL_RST;
      sel_reg <= `OMT_SEL_RST;
      mask_reg <= `OMT_MASK_RST;
    end else if (wr_i) begin
      if (addr_i == `OMT_ADDR_CTRL && !tuning) begin
        ctrl_reg <= wdata_i[3:0];
      end
      if (tsel_wr && !tuning) begin
        sel_reg <= wdata_i[7:0];
      end
      if (addr_i == `OMT_ADDR_MASK) begin
        mask_reg <= wdata_i[2:0];
      end
    end
  end

  // sticky events, read clears, set wins
  always_comb begin
    irq_st_next = irq_st_reg;
    if (rd_i && addr_i == `OMT_ADDR_IRQ) begin
      irq_st_next = 3'h0;
    end
    if (state_reg == omt_pkg::OMT_ARMED && start_req) begin
      irq_st_next[`OMT_IRQ_START] = 1'b1;
    end
    if (tuning && !err_hit && tune_done) begin
      irq_st_next[`OMT_IRQ_OK] = 1'b1;
    end
    if (tuning && err_hit) begin
      irq_st_next[`OMT_IRQ_ERR] = 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      irq_st_reg <= 3'h0;
      irq_reg <= 1'b0;
    end else begin
      irq_st_reg <= irq_st_next;
      irq_reg <= |(irq_st_next & mask_reg);
    end
  end

  always_comb begin
    unique case (state_reg)
      omt_pkg::OMT_ARMED: tsel_rd = `OMT_SEL_TUNE;
      omt_pkg::OMT_RUNNING: tsel_rd = `OMT_ST_RUN;
      omt_pkg::OMT_DONE_OK: tsel_rd = `OMT_ST_OK;
      omt_pkg::OMT_DONE_ERR: tsel_rd = err_code_reg;
      default: tsel_rd = sel_reg;
    endcase
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_reg <= 32'h0;
    end else if (rd_i) begin
      unique case (addr_i)
        `OMT_ADDR_CTRL: rdata_reg <= {28'h0, ctrl_reg};
        `OMT_ADDR_TSEL: rdata_reg <= {24'h0, tsel_rd};
        `OMT_ADDR_ERR: rdata_reg <= {24'h0, err_code_reg};
        `OMT_ADDR_R1: rdata_reg <= {15'h0, r1_valid_reg, r1_reg};
        `OMT_ADDR_IRQ: rdata_reg <= {29'h0, irq_st_reg};
        `OMT_ADDR_MASK: rdata_reg <= {29'h0, mask_reg};
        default: rdata_reg <= 32'h0;
      endcase
    end else begin
      rdata_reg <= 32'h0;
    end
  end

  // drive outputs; normal run only from idle
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      run_cmd_reg <= 1'b0;
      motion_reg <= 1'b0;
    end else begin
      run_cmd_reg <= (state_reg == omt_pkg::OMT_IDLE) &&
        pwr_ok && start_lvl;
      motion_reg <= run_now || ((state_reg == omt_pkg::OMT_IDLE) &&
        pwr_ok && start_lvl);
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      analog_reg <= 8'h00;
      fault_relay_reg <= 1'b0;
      set_freq_reg <= 8'h00;
      aux_out_reg <= 4'h0;
    end else begin
      fault_relay_reg <= sync2_reg[P_TRIP];
      if (tuning && ctrl_reg[`OMT_CTRL_MON_MSB:`OMT_CTRL_MON_LSB]
          <= `OMT_MON_FREQ) begin
        analog_reg <= {step_reg, 5'h00};
      end else begin
        analog_reg <= monitor_i;
      end
      set_freq_reg <= tuning ? 8'h00 : set_freq_i;
      aux_out_reg <= tuning ? 4'h0 : aux_out_i;
    end
  end

  assign rdata_o = rdata_reg;
  assign irq_o = irq_reg;
  assign run_cmd_o = run_cmd_reg;
  assign motion_active_o = motion_reg;
  assign analog_monitor_output_o = analog_reg;
  assign fault_relay_o = fault_relay_reg;
  assign set_freq_mon_o = set_freq_reg;
  assign aux_out_o = aux_out_reg;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  property p_start_motion;
    state_reg == omt_pkg::OMT_ARMED && start_req |=>
      motion_active_o && tuning;
  endproperty
  a_start_motion: assert property (p_start_motion)
    else $error("motion not raised at start");

  property p_forced;
    tuning && pwr_ok && !sync2_reg[P_TRIP] && sync2_reg[P_MRS] |=>
      state_reg == omt_pkg::OMT_DONE_ERR &&
      err_code_reg == `OMT_ERR_FORCED;
  endproperty
  a_forced: assert property (p_forced)
    else $error("shutoff did not force end");

  property p_ilim;
    tuning && pwr_ok && !sync2_reg[P_TRIP] && !forced_end &&
      sync2_reg[P_ILIM] && !stall_off |=>
      err_code_reg == `OMT_ERR_ILIM;
  endproperty
  a_ilim: assert property (p_ilim)
    else $error("current limit code wrong");

  property p_err_keeps;
    state_reg == omt_pkg::OMT_DONE_ERR |=>
      $stable(r1_reg) && !run_cmd_o;
  endproperty
  a_err_keeps: assert property (p_err_keeps)
    else $error("constants changed after error");

  property p_status_run;
    tuning && rd_i && addr_i == `OMT_ADDR_TSEL |=>
      rdata_o == 32'h16;
  endproperty
  a_status_run: assert property (p_status_run)
    else $error("status not 22 while tuning");

  property p_zero_freq;
    tuning |=> set_freq_mon_o == 8'h00 && aux_out_o == 4'h0;
  endproperty
  a_zero_freq: assert property (p_zero_freq)
    else $error("monitor not zero while tuning");

  property p_done;
    tuning && !err_hit && tune_done |=>
      state_reg == omt_pkg::OMT_DONE_OK && r1_valid_reg &&
      r1_reg == $past(meas_r1_i);
  endproperty
  a_done: assert property (p_done)
    else $error("constants not stored at end");

  property p_invalid;
    tsel_wr && r1_valid_reg && wdata_i[7:0] != sel_reg &&
      !tuning |=> !r1_valid_reg;
  endproperty
  a_invalid: assert property (p_invalid)
    else $error("data still valid after change");

  property p_hold_ok;
    state_reg == omt_pkg::OMT_DONE_OK && !ack |=>
      state_reg == omt_pkg::OMT_DONE_OK ##1 !run_cmd_o;
  endproperty
  a_hold_ok: assert property (p_hold_ok)
    else $error("left normal end without acknowledge");

  property p_hold_err;
    state_reg == omt_pkg::OMT_DONE_ERR && !fclr_rise &&
      !pwr_rise |=> state_reg == omt_pkg::OMT_DONE_ERR;
  endproperty
  a_hold_err: assert property (p_hold_err)
    else $error("left error end without reset");

  property p_relay;
    sync2_reg[P_TRIP] |=> fault_relay_o;
  endproperty
  a_relay: assert property (p_relay)
    else $error("fault relay missed trip");

  c_normal: cover property (tuning ##1
    state_reg == omt_pkg::OMT_DONE_OK);
  c_error: cover property (tuning ##1
    state_reg == omt_pkg::OMT_DONE_ERR);
  c_ack: cover property (state_reg == omt_pkg::OMT_DONE_OK ##1
    state_reg == omt_pkg::OMT_IDLE);
  c_irq: cover property ($rose(irq_o));

endmodule : omt_tuning_seq

// ---- src/omt_consts.svh ----
`ifndef OMT_CONSTS_SVH
`define OMT_CONSTS_SVH
`define OMT_ADDR_CTRL 8'h00
`define OMT_ADDR_TSEL 8'h04
`define OMT_ADDR_ERR 8'h08
`define OMT_ADDR_R1 8'h0C
`define OMT_ADDR_IRQ 8'h10
`define OMT_ADDR_MASK 8'h14
`define OMT_CTRL_PU 0
`define OMT_CTRL_MON_LSB 1
`define OMT_CTRL_MON_MSB 2
`define OMT_CTRL_STALL_OFF 3
`define OMT_CTRL_RST 4'h0
`define OMT_MASK_RST 3'h0
`define OMT_SEL_RST 8'h00
`define OMT_MON_SPEED 2'h0
`define OMT_MON_FREQ 2'h1
`define OMT_SEL_TUNE 8'h15
`define OMT_ST_RUN 8'h16
`define OMT_ST_OK 8'h17
`define OMT_ERR_NONE 8'h00
`define OMT_ERR_FORCED 8'h08
`define OMT_ERR_TRIP 8'h09
`define OMT_ERR_ILIM 8'h5B
`define OMT_ERR_DCV 8'h5C
`define OMT_ERR_CALC 8'h5D
`define OMT_IRQ_START 0
`define OMT_IRQ_OK 1
`define OMT_IRQ_ERR 2
`define OMT_TUNE_TIME_MS 9000
`define OMT_CLK_KHZ 100000
`define OMT_STEPS 8
`endif

// ---- src/omt_pkg.sv ----
package omt_pkg;
  typedef enum logic [2:0] {
    OMT_IDLE,
    OMT_ARMED,
    OMT_RUNNING,
    OMT_DONE_OK,
    OMT_DONE_ERR
  } omt_state_t;
endpackage : omt_pkg

// ---- tb/omt_panel_model.sv ----
// panel keys, start inputs and fault levels seen by the sequencer
// lvl_o: 0 shutoff, 1 fault clear, 2 main power, 3 trip, 4 ilim, 5 dc, 6 calc
module omt_panel_model (
  input wire logic clk_i,
  output logic run_key_o,
  output logic stop_key_o,
  output logic fwd_o,
  output logic rev_o,
  output logic [6:0] lvl_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    run_key_o = 1'b0;
    stop_key_o = 1'b0;
    fwd_o = 1'b0;
    rev_o = 1'b0;
    lvl_o = 7'h04; // power up before any run command
  end
  task automatic start(input logic f, input logic r);
    @(posedge clk_i);
    fwd_o <= f;
    rev_o <= r;
  endtask : start
  task automatic level(input int i, input logic v);
    @(posedge clk_i);
    lvl_o[i] <= v;
  endtask : level
  // press and release, long enough for the synchronisers
  task automatic press(input int k);
    repeat (2) begin
      @(posedge clk_i);
      case (k)
        0: run_key_o <= ~run_key_o;
        1: stop_key_o <= ~stop_key_o;
        default: lvl_o[1] <= ~lvl_o[1];
      endcase
      repeat (3) @(posedge clk_i);
    end
  endtask : press
endmodule : omt_panel_model

// ---- tb/testbench.sv ----
`include "omt_consts.svh"
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin bad_count++; \
  $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i, resetn_i, wr_i, rd_i, irq_o, rk, sk, fwd, rev;
  logic run_cmd, mact, frelay;
  logic [7:0] addr_i, mon, am, sfm, prev, sfi;
  logic [31:0] wdata_i, rdata_o, rdv;
  logic [6:0] lvl;
  logic [15:0] meas;
  logic [3:0] aux, auxi;
  int bad_count, n_checks, cyc, n, act_cnt, steps;
  int src[6] = '{0, 3, 4, 5, 6, 0};
  logic [7:0] code[6] = '{`OMT_ERR_FORCED, `OMT_ERR_TRIP, `OMT_ERR_ILIM,
    `OMT_ERR_DCV, `OMT_ERR_CALC, `OMT_ERR_FORCED};
  omt_tuning_seq #(.TUNE_CYCLES(80)) i_dut (
    .clk_i(clk_i), .resetn_i(resetn_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .irq_o(irq_o), .run_key_i(rk), .stop_key_i(sk),
    .forward_start_input_i(fwd), .reverse_start_input_i(rev),
    .output_shutoff_input_i(lvl[0]), .fault_clear_input_i(lvl[1]),
    .main_power_ok_i(lvl[2]), .protective_trip_i(lvl[3]),
    .current_limit_i(lvl[4]), .dc_bus_high_i(lvl[5]),
    .calc_error_i(lvl[6]), .meas_r1_i(meas), .monitor_i(mon),
    .set_freq_i(sfi), .aux_out_i(auxi), .run_cmd_o(run_cmd),
    .motion_active_o(mact), .analog_monitor_output_o(am),
    .fault_relay_o(frelay), .set_freq_mon_o(sfm), .aux_out_o(aux)
  );
  omt_panel_model i_panel (
    .clk_i(clk_i), .run_key_o(rk), .stop_key_o(sk), .fwd_o(fwd),
    .rev_o(rev), .lvl_o(lvl)
  );
  task automatic close_out();
    if (bad_count == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : close_out
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    @(negedge clk_i);
    rdv = rdata_o;
  endtask : rd
  task automatic wait_act();
    n = 0;
    while (mact !== 1'b1 && n < 20) begin
      @(negedge clk_i);
      n++;
    end
  endtask : wait_act
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      close_out();
    end
  end
  // tuning length and monitor steps of the run
  always @(negedge clk_i) begin
    if (mact === 1'b1) begin
      act_cnt++;
      if (am !== prev) begin
        steps++;
      end
      prev = am;
    end
  end
  initial begin
    resetn_i = 1'b0;
    wr_i = 1'b0;
    rd_i = 1'b0;
    addr_i = 8'h00;
    wdata_i = 32'h0;
    meas = 16'h1234;
    mon = 8'h00;
    sfi = 8'h3C;
    auxi = 4'hA;
    prev = 8'h00;
    repeat (10) @(posedge clk_i);
    resetn_i <= 1'b1;
    rd(`OMT_ADDR_TSEL);
    `CHK("tsel_rst", 32'h0, rdv)
    rd(8'h20);
    `CHK("unmapped", 32'h0, rdv)
    `CHK("setf_idle", 8'h3C, sfm)
    `CHK("aux_idle", 4'hA, aux)
    wr(`OMT_ADDR_MASK, 32'h7);
    wr(`OMT_ADDR_TSEL, 32'h15);
    rd(`OMT_ADDR_TSEL);
    `CHK("tsel_set", 32'h15, rdv)
    i_panel.start(1'b1, 1'b0);
    wait_act();
    `CHK("act_delay", 1'b1, n <= 6)
    rd(`OMT_ADDR_TSEL);
    `CHK("tsel_run", 32'h16, rdv)
    `CHK("setf_mon", 8'h00, sfm)
    `CHK("aux_out", 4'h0, aux)
    `CHK("irq_start", 1'b1, irq_o)
    rd(`OMT_ADDR_IRQ);
    `CHK("irq_st0", 1'b1, rdv[0])
    n = 0;
    while (mact === 1'b1 && n < 200) begin
      @(negedge clk_i);
      n++;
    end
    `CHK("tune_len", 1'b1, act_cnt >= 79 && act_cnt <= 81)
    `CHK("steps", 7, steps)
    `CHK("last_step", 8'hE0, prev)
    rd(`OMT_ADDR_TSEL);
    `CHK("tsel_ok", 32'h17, rdv)
    rd(`OMT_ADDR_R1);
    `CHK("r1_ok", 32'h11234, rdv)
    rd(`OMT_ADDR_IRQ);
    `CHK("irq_ok", 1'b1, rdv[1])
    `CHK("refuse_run", 1'b0, run_cmd)
    i_panel.start(1'b0, 1'b0);
    repeat (6) @(negedge clk_i);
    rd(`OMT_ADDR_TSEL);
    `CHK("ack_idle", 32'h15, rdv)
    wr(`OMT_ADDR_TSEL, 32'h0);
    rd(`OMT_ADDR_R1);
    `CHK("r1_inval", 32'h01234, rdv)
    meas <= 16'h0F0F;
    for (int k = 0; k < 6; k++) begin
      wr(`OMT_ADDR_TSEL, 32'h15);
      i_panel.start(k[0], !k[0]);
      wait_act();
      if (k < 5) begin
        i_panel.level(src[k], 1'b1);
      end else begin
        i_panel.start(1'b0, 1'b0);
      end
      repeat (8) @(negedge clk_i);
      if (k == 1) begin
        `CHK("relay", 1'b1, frelay)
      end
      rd(`OMT_ADDR_ERR);
      `CHK("err_code", {24'h0, code[k]}, rdv)
      rd(`OMT_ADDR_TSEL);
      `CHK("tsel_err", {24'h0, code[k]}, rdv)
      rd(`OMT_ADDR_R1);
      `CHK("r1_kept", 32'h01234, rdv)
      `CHK("err_norun", 1'b0, run_cmd)
      if (k < 5) begin
        i_panel.level(src[k], 1'b0);
      end
      i_panel.start(1'b0, 1'b0);
      i_panel.press(2);
      rd(`OMT_ADDR_TSEL);
      `CHK("reset_idle", 32'h15, rdv)
    end
    wr(`OMT_ADDR_CTRL, 32'h2);
    mon <= 8'h5A;
    wr(`OMT_ADDR_TSEL, 32'h15);
    i_panel.start(1'b1, 1'b0);
    wait_act();
    @(negedge clk_i);
    `CHK("am_freq", 8'h00, am)
    i_panel.level(2, 1'b0);
    repeat (8) @(negedge clk_i);
    rd(`OMT_ADDR_ERR);
    `CHK("pwr_err", {24'h0, `OMT_ERR_TRIP}, rdv)
    i_panel.level(2, 1'b1);
    repeat (8) @(negedge clk_i);
    `CHK("pwr_run", 1'b1, run_cmd)
    i_panel.start(1'b0, 1'b0);
    wr(`OMT_ADDR_MASK, 32'h0);
    wr(`OMT_ADDR_CTRL, 32'h5);
    rd(`OMT_ADDR_IRQ);
    wr(`OMT_ADDR_TSEL, 32'h15);
    mon <= 8'h5A;
    i_panel.press(0);
    wait_act();
    `CHK("panel_start", 1'b1, n < 20)
    `CHK("am_other", 8'h5A, am)
    `CHK("irq_masked", 1'b0, irq_o)
    rd(`OMT_ADDR_IRQ);
    `CHK("irq_sticky", 1'b1, rdv[0])
    rd(`OMT_ADDR_IRQ);
    `CHK("irq_clear", 32'h0, rdv)
    i_panel.press(1);
    repeat (6) @(negedge clk_i);
    rd(`OMT_ADDR_ERR);
    `CHK("stop_key", {24'h0, `OMT_ERR_FORCED}, rdv)
    close_out();
  end
endmodule : testbench
